// ### rtl/scg_clock_gen.sv
// system clock generation: source select, system pll, audio pll, base and branch clocks
// Contract
// [R01] after any reset every base clock takes the internal rc oscillator
// [R02] system pll leaves reset powered down and bypassed, input passing through
// [R03] software configures, enables, awaits lock, then selects the pll output
// [R04] lock is reported only after the full 100 us settling time
// [R05] feedback multiplier accepts every integer from 1 to 32
// [R06] post divider offers 2, 4, 8, 16 only, giving 50 percent duty
// [R07] software keeps the controlled oscillator between 156 and 320 MHz
// [R08] several base clocks, each with its own independent source select
// [R09] one selected base clock drives the clock output pin; base 0 is cpu
// [R10] every branch clock comes from one of two gating units, enabled alone
// [R11] branch clocks of one base share frequency and phase, no gating skew
// [R12] audio pll output settable to 32..512 times the sampling frequency
// [R13] source changes and gate changes never truncate or glitch a clock
module scg_clock_gen
  import scg_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  internal_rc_oscillator,
  input  wire logic                  xtal_clk,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [NUM_BASE-1:0]        base_clk,
  output logic                       cpu_clock,
  output logic                       clock_output_pin,
  output logic [NUM_BRANCH-1:0]      branch_clk,
  output logic                       system_pll_locked,
  output logic                       audio_pll_clk
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sync1_q, sync2_q, sync3_q, src_in_q;

  always_ff @(posedge mclk) begin
    sync1_q <= {xtal_clk, internal_rc_oscillator};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      src_in_q <= 2'b00;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (sync2_q[k] == sync3_q[k]) begin
          src_in_q[k] <= sync3_q[k];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]            pll_ctrl_q;
  scg_pll_cfg_s          pll_cfg_q;
  logic [2*NUM_BASE-1:0] base_sel_q;
  logic [NUM_BRANCH-1:0] branch_en_q;
  logic [1:0]            clock_output_pin_sel_q;
  logic [2:0]            audio_cfg_q;
  logic [31:0]           audio_step_q;

  logic       wr_go, rd_go;
  logic [7:0] wr_addr;
  logic       wr_hit, rd_hit;
  logic [31:0] rd_val;

  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign wr_addr       = {s_axi_awaddr[7:2], 2'b00};
  assign rd_go         = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_arready = rd_go;

  always_comb begin
    case (wr_addr)
      OFS_PLL_CTRL, OFS_PLL_CFG, OFS_BASE_SEL, OFS_BRANCH_EN,
      OFS_CLOCK_OUTPUT_PIN_SEL, OFS_AUDIO_CFG, OFS_AUDIO_STEP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_ctrl_q   <= RST_PLL_CTRL; // see [R02]
      pll_cfg_q    <= '{psel: RST_PSEL, msel: RST_MSEL};
      base_sel_q   <= {NUM_BASE{RST_SRC}}; // see [R01]
      branch_en_q  <= RST_BRANCH_EN;
      clock_output_pin_sel_q <= 2'h0;
      audio_cfg_q  <= RST_AUDIO_MULT;
      audio_step_q <= RST_AUDIO_STEP;
    end else if (wr_go && s_axi_wstrb[0]) begin
      case (wr_addr)
        OFS_PLL_CTRL: pll_ctrl_q <= s_axi_wdata[2:0];
        OFS_PLL_CFG: begin
          pll_cfg_q.msel <= s_axi_wdata[CFG_MSEL_LSB +: 5]; // see [R05]
          pll_cfg_q.psel <= s_axi_wdata[CFG_PSEL_LSB +: 2]; // see [R06]
        end
        OFS_BASE_SEL:   base_sel_q   <= s_axi_wdata[2*NUM_BASE-1:0]; // see [R08]
        OFS_BRANCH_EN:  branch_en_q  <= s_axi_wdata[NUM_BRANCH-1:0]; // see [R10]
        OFS_CLOCK_OUTPUT_PIN_SEL: clock_output_pin_sel_q <= s_axi_wdata[1:0];
        OFS_AUDIO_CFG: begin
          if (s_axi_wdata[2:0] <= 3'd5) begin
            audio_cfg_q <= s_axi_wdata[2:0]; // see [R12]
          end
        end
        OFS_AUDIO_STEP: audio_step_q <= s_axi_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // system pll
  // ----------------------------------------------------------------
  scg_pll_e    pll_st_q;
  logic [15:0] lock_cnt_q;
  logic [3:0]  div_cnt_q;
  logic        spll_in, spll_out;

  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_st_q   <= PLL_OFF; // see [R02]
      lock_cnt_q <= 16'h0000;
    end else if (!pll_ctrl_q[CTRL_PWR_UP]) begin
      pll_st_q   <= PLL_OFF;
      lock_cnt_q <= 16'h0000;
    end else begin
      unique case (pll_st_q)
        PLL_OFF: begin
          pll_st_q   <= PLL_LOCKING;
          lock_cnt_q <= 16'h0000;
        end
        PLL_LOCKING: begin
          lock_cnt_q <= lock_cnt_q + 16'h0001;
          if (lock_cnt_q >= 16'(LOCK_CYC - 1)) begin
            pll_st_q <= PLL_LOCKED; // see [R04]
          end
        end
        PLL_LOCKED: ;
        default: pll_st_q <= PLL_OFF;
      endcase
    end
  end

  // free-running divider behind the pll output
  always_ff @(posedge mclk) begin
    if (rst) begin
      div_cnt_q <= 4'h0;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end

  assign system_pll_locked = (pll_st_q == PLL_LOCKED);
  assign spll_in  = pll_ctrl_q[CTRL_IN_XTAL] ? src_in_q[1] : src_in_q[0];
  // divide by 2 << psel taps a binary counter bit, so duty is exactly half
  assign spll_out = pll_ctrl_q[CTRL_BYPASS] ? spll_in // see [R02]
                  : (system_pll_locked && div_cnt_q[pll_cfg_q.psel]); // see [R03] [R06]

  // ----------------------------------------------------------------
  // audio pll
  // ----------------------------------------------------------------
  logic [41:0] audio_inc;
  logic [31:0] audio_acc_q;

  assign audio_inc = 42'(scg_audio_mult(audio_cfg_q)) * 42'(audio_step_q); // see [R12]

  always_ff @(posedge mclk) begin
    if (rst) begin
      audio_acc_q   <= 32'h0000_0000;
      audio_pll_clk <= 1'b0;
    end else begin
      audio_acc_q   <= audio_acc_q + audio_inc[31:0];
      audio_pll_clk <= audio_acc_q[31];
    end
  end

  // ----------------------------------------------------------------
  // base clock multiplexers
  // ----------------------------------------------------------------
  logic [NUM_SRC-1:0]    src_lvl;
  logic [1:0]            act_sel_q [NUM_BASE];
  logic [NUM_BASE-1:0]   base_d;
  logic [NUM_BASE-1:0]   base_q;

  assign src_lvl = {audio_pll_clk, spll_out, src_in_q[1], src_in_q[0]};

  always_comb begin
    for (int i = 0; i < NUM_BASE; i++) begin
      base_d[i] = src_lvl[act_sel_q[i]];
    end
  end

  // switch only while old output and new source are both low
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < NUM_BASE; i++) begin
        act_sel_q[i] <= SRC_IRC; // see [R01]
      end
      base_q <= '0;
    end else begin
      for (int i = 0; i < NUM_BASE; i++) begin
        if (!base_q[i] && !base_d[i] && !src_lvl[base_sel_q[2*i +: 2]]) begin
          act_sel_q[i] <= base_sel_q[2*i +: 2]; // see [R13]
        end
      end
      base_q <= base_d; // see [R08]
    end
  end

  assign base_clk  = base_q;
  assign cpu_clock = base_q[0]; // see [R09]

  // ----------------------------------------------------------------
  // clock output pin
  // ----------------------------------------------------------------
  logic [1:0] clock_output_pin_act_q;
  logic       clock_output_pin_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      clock_output_pin_act_q <= 2'h0;
      clock_output_pin_q     <= 1'b0;
    end else begin
      if (!clock_output_pin_q && !base_d[clock_output_pin_act_q] && !base_d[clock_output_pin_sel_q]) begin
        clock_output_pin_act_q <= clock_output_pin_sel_q; // see [R13]
      end
      clock_output_pin_q <= base_d[clock_output_pin_act_q]; // see [R09]
    end
  end

  assign clock_output_pin = clock_output_pin_q;

  // ----------------------------------------------------------------
  // branch gating units
  // ----------------------------------------------------------------
  logic [NUM_BRANCH-1:0] en_act_q, en_act_d, branch_d, branch_q;
  localparam int PER_UNIT = NUM_BASE * BR_PER_UNIT;

  always_comb begin
    for (int b = 0; b < NUM_BRANCH; b++) begin
      // unit = b / PER_UNIT, base = (b % PER_UNIT) / BR_PER_UNIT
      en_act_d[b] = base_d[(b % PER_UNIT) / BR_PER_UNIT] ? en_act_q[b]
                  : branch_en_q[b]; // see [R13]
      branch_d[b] = base_d[(b % PER_UNIT) / BR_PER_UNIT] & en_act_d[b]; // see [R10]
    end
  end

  // base and branches load from one next value on one edge, so no skew
  always_ff @(posedge mclk) begin
    if (rst) begin
      en_act_q <= RST_BRANCH_EN;
      branch_q <= '0;
    end else begin
      en_act_q <= en_act_d;
      branch_q <= branch_d; // see [R11]
    end
  end

  assign branch_clk = branch_q;

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      OFS_PLL_CTRL:   rd_val[2:0] = pll_ctrl_q;
      OFS_PLL_CFG: begin
        rd_val[CFG_MSEL_LSB +: 5] = pll_cfg_q.msel;
        rd_val[CFG_PSEL_LSB +: 2] = pll_cfg_q.psel;
      end
      OFS_STATUS: begin
        rd_val[1:0] = pll_st_q;
        for (int i = 0; i < NUM_BASE; i++) begin
          rd_val[8 + 2*i +: 2] = act_sel_q[i];
        end
        rd_val[17:16] = clock_output_pin_act_q;
      end
      OFS_BASE_SEL:   rd_val[2*NUM_BASE-1:0] = base_sel_q;
      OFS_BRANCH_EN:  rd_val[NUM_BRANCH-1:0] = en_act_q;
      OFS_CLOCK_OUTPUT_PIN_SEL: rd_val[1:0] = clock_output_pin_sel_q;
      OFS_AUDIO_CFG:  rd_val[2:0] = audio_cfg_q;
      OFS_AUDIO_STEP: rd_val = audio_step_q;
      default:        rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : scg_clock_gen

// ### rtl/scg_pkg.sv
// package: constants, register map and types of the system clock generator
package scg_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NUM_BASE    = 4;
  localparam int NUM_UNIT    = 2;
  localparam int BR_PER_UNIT = 2;
  localparam int NUM_BRANCH  = NUM_BASE * NUM_UNIT * BR_PER_UNIT;
  localparam int NUM_SRC     = 4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_LOCK_US   = 100;
  localparam int PLL_LOCK_CYC  = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PLL_CTRL   = 8'h00;
  localparam logic [7:0] OFS_PLL_CFG    = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_BASE_SEL   = 8'h0C;
  localparam logic [7:0] OFS_BRANCH_EN  = 8'h10;
  localparam logic [7:0] OFS_CLOCK_OUTPUT_PIN_SEL = 8'h14;
  localparam logic [7:0] OFS_AUDIO_CFG  = 8'h18;
  localparam logic [7:0] OFS_AUDIO_STEP = 8'h1C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_PWR_UP  = 0;
  localparam int CTRL_BYPASS  = 1;
  localparam int CTRL_IN_XTAL = 2;
  localparam int CFG_MSEL_LSB = 0;
  localparam int CFG_PSEL_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  RST_PLL_CTRL   = 3'h2;
  localparam logic [4:0]  RST_MSEL       = 5'h0;
  localparam logic [1:0]  RST_PSEL       = 2'h0;
  localparam logic [1:0]  RST_SRC        = 2'h0;
  localparam logic [15:0] RST_BRANCH_EN  = 16'hFFFF;
  localparam logic [2:0]  RST_AUDIO_MULT = 3'h3;
  localparam logic [31:0] RST_AUDIO_STEP = 32'h0000_0000;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_IRC   = 2'h0;
  localparam logic [1:0] SRC_XTAL  = 2'h1;
  localparam logic [1:0] SRC_SPLL  = 2'h2;
  localparam logic [1:0] SRC_AUDIO = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PLL_OFF     = 2'b00,
    PLL_LOCKING = 2'b01,
    PLL_LOCKED  = 2'b11
  } scg_pll_e;

  typedef struct packed {
    logic [1:0] psel;
    logic [4:0] msel;
  } scg_pll_cfg_s;

  // audio multiples of fs, by code 0..5
  function automatic logic [9:0] scg_audio_mult(input logic [2:0] code);
    case (code)
      3'd0:    return 10'd32;
      3'd1:    return 10'd64;
      3'd2:    return 10'd128;
      3'd3:    return 10'd256;
      3'd4:    return 10'd384;
      default: return 10'd512;
    endcase
  endfunction : scg_audio_mult

endpackage : scg_pkg

// ### verif/scg_clock_gen_asserts.sv
// checker: concurrent assertions on the clock generator ports
module scg_clock_gen_asserts
  import scg_pkg::*;
#(
  parameter int LOCK_CYC = PLL_LOCK_CYC
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_wvalid,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic                  s_axi_arvalid,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  input wire logic [NUM_BASE-1:0]   base_clk,
  input wire logic                  cpu_clock,
  input wire logic                  clock_output_pin,
  input wire logic [NUM_BRANCH-1:0] branch_clk,
  input wire logic                  system_pll_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic [15:0] low_q;
  logic [15:0] base_mask;
  assign base_mask = {2{base_clk[3], base_clk[3], base_clk[2], base_clk[2],
                        base_clk[1], base_clk[1], base_clk[0], base_clk[0]}};
  // cycles since lock was last seen
  always_ff @(posedge mclk) begin
    if (rst || system_pll_locked) low_q <= 16'h0000;
    else if (low_q != 16'hFFFF) low_q <= low_q + 16'h0001;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_cpu_base0: assert property (cpu_clock == base_clk[0])
    else $error("cpu clock differs from base clock 0");
  chk_clock_output_pin_base: assert property (clock_output_pin == base_clk[0] ||
      clock_output_pin == base_clk[1] || clock_output_pin == base_clk[2] ||
      clock_output_pin == base_clk[3])
    else $error("clock output follows no base clock");
  chk_branch_gated: assert property ((branch_clk & ~base_mask) == 16'h0000)
    else $error("branch clock high while its base is low");
  chk_lock_settle: assert property ($rose(system_pll_locked)
      |-> low_q >= 16'(LOCK_CYC))
    else $error("pll lock reported before settling time");
  chk_unlock_write: assert property ($fell(system_pll_locked)
      |-> $past(s_axi_bvalid))
    else $error("pll lock lost without a register write");
  chk_write_answer: assert property ((s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)
      |=> s_axi_bvalid)
    else $error("write response missing");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_read_answer: assert property ((s_axi_arvalid && !s_axi_rvalid) |=> s_axi_rvalid)
    else $error("read response missing");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule : scg_clock_gen_asserts

bind scg_clock_gen scg_clock_gen_asserts #(.LOCK_CYC(LOCK_CYC)) u_chk (
  .mclk, .rst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .base_clk, .cpu_clock, .clock_output_pin, .branch_clk, .system_pll_locked
);

// ### verif/tb_top.sv
// testbench: register scenarios and clock measurements for the clock generator
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scg_pkg::*;
  localparam int LCYC = 20;
  logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic rc_q = 1'b0, xt_q = 1'b0;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, cpu_clock, clock_output_pin, system_pll_locked;
  logic audio_pll_clk;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, base_clk;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] branch_clk;
  int          num_errors, n_compared, r, h, n;
  int          rc_n = 0, xt_n = 0;
  logic [31:0] d, seen;
  int          mults[6] = '{32, 64, 128, 256, 384, 512};

  scg_clock_gen #(.LOCK_CYC(LCYC)) uut (
    .mclk, .rst, .internal_rc_oscillator(rc_q), .xtal_clk(xt_q), .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .base_clk, .cpu_clock,
    .clock_output_pin, .branch_clk, .system_pll_locked, .audio_pll_clk
  );
  // ----------------------------------------------------------------
  // clocks and sources: rc period 8 cycles, crystal period 6 cycles
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    rc_n <= (rc_n + 1) % 8;
    xt_n <= (xt_n + 1) % 6;
    rc_q <= (rc_n < 4);
    xt_q <= (xt_n < 3);
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic rng(input int v, input int lo, input int hi, input string what);
    check(32'(v >= lo && v <= hi), 32'h0000_0001, what);
  endtask : rng
  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] exp);
    s_axi_awaddr <= a;
    s_axi_wdata <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge mclk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge mclk); while (!s_axi_bvalid);
    check(32'({s_axi_bvalid, s_axi_bresp}), 32'({1'b1, exp}), "write response");
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] dat, input logic [1:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (!s_axi_rvalid);
    dat = s_axi_rdata;
    check(32'({s_axi_rvalid, s_axi_rresp}), 32'({1'b1, exp}), "read response");
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    logic [31:0] v;
    rd(a, v, RESP_OKAY);
    check(v & m, e, what);
  endtask : rdc
  // count rises and high cycles of base 0..3, audio (4) or clock output (5)
  task automatic meas(input int sel, input int cyc, output int rises, output int highs);
    logic v, p;
    rises = 0;
    highs = 0;
    p = 1'b1;
    repeat (cyc) begin
      @(posedge mclk);
      v = (sel < 4) ? base_clk[sel] : (sel == 4) ? audio_pll_clk : clock_output_pin;
      rises += int'(v && !p);
      highs += int'(v);
      p = v;
    end
  endtask : meas
  task automatic close_out();
    $display("checks %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rst <= 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check(32'(system_pll_locked), 32'h0000_0000, "lock after reset");
    rdc(OFS_PLL_CTRL, 32'h0000_0007, 32'h0000_0002, "pll off and bypassed");
    rdc(OFS_STATUS, 32'h0003_FF03, 32'h0000_0000, "rc sources after reset");
    meas(0, 64, r, h);
    rng(r, 7, 9, "base 0 runs from rc");
  endtask : t_reset
  task automatic t_pll();
    wr(8'h20, 32'h0000_0001, RESP_SLVERR);
    rd(8'h24, d, RESP_SLVERR);
    wr(OFS_PLL_CFG, 32'h0000_001F, RESP_OKAY);
    rdc(OFS_PLL_CFG, 32'h0000_031F, 32'h0000_001F, "multiplier 32");
    wr(OFS_PLL_CFG, 32'h0000_0013, RESP_OKAY);
    for (int q = 0; q < 2; q++) begin
      wr(OFS_PLL_CTRL, 32'h0000_0001, RESP_OKAY);
      repeat (LCYC - 6) @(posedge mclk);
      rdc(OFS_STATUS, 32'h0000_0003, 32'h0000_0001, "still locking");
      n = 0;
      while (system_pll_locked !== 1'b1 && n < 40) begin @(posedge mclk); n++; end
      rdc(OFS_STATUS, 32'h0000_0003, 32'h0000_0003, "pll locked");
      if (q == 0) begin
        wr(OFS_PLL_CTRL, 32'h0000_0002, RESP_OKAY);
        rdc(OFS_STATUS, 32'h0000_0003, 32'h0000_0000, "pll powered down");
      end
    end
    wr(OFS_BASE_SEL, 32'h0000_0008, RESP_OKAY);
    wr(OFS_PLL_CTRL, 32'h0000_0003, RESP_OKAY);
    repeat (20) @(posedge mclk);
    meas(1, 64, r, h);
    rng(r, 7, 9, "bypass passes input");
    wr(OFS_PLL_CTRL, 32'h0000_0001, RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      wr(OFS_PLL_CFG, 32'((p << 8) | (12 + p * 4)), RESP_OKAY);
      rdc(OFS_PLL_CFG, 32'h0000_031F, 32'((p << 8) | (12 + p * 4)), "pll config");
      repeat (40) @(posedge mclk);
      meas(1, 64, r, h);
      rng(r, 64 / (2 << p) - 1, 64 / (2 << p) + 1, "post divider");
      rng(h, 32, 32, "post divider duty");
    end
  endtask : t_pll
  task automatic t_audio();
    wr(OFS_AUDIO_STEP, 32'h0020_0000, RESP_OKAY);
    for (int c = 0; c < 6; c++) begin
      wr(OFS_AUDIO_CFG, 32'(c), RESP_OKAY);
      rdc(OFS_AUDIO_CFG, 32'h0000_0007, 32'(c), "audio multiple code");
      meas(4, 256, r, h);
      rng(r, mults[c] / 8 - 1, mults[c] / 8 + 1, "audio rate");
    end
    wr(OFS_AUDIO_CFG, 32'h0000_0006, RESP_OKAY);
    rdc(OFS_AUDIO_CFG, 32'h0000_0007, 32'h0000_0005, "bad audio code ignored");
    s_axi_wstrb <= 4'h0;
    wr(OFS_AUDIO_CFG, 32'h0000_0000, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdc(OFS_AUDIO_CFG, 32'h0000_0007, 32'h0000_0005, "masked write ignored");
  endtask : t_audio
  task automatic t_src();
    wr(OFS_BASE_SEL, 32'h0000_00D8, RESP_OKAY);
    repeat (40) @(posedge mclk);
    rdc(OFS_STATUS, 32'h0000_FF00, 32'h0000_D800, "independent sources");
    meas(2, 60, r, h);
    rng(r, 9, 11, "base 2 on crystal");
    meas(3, 64, r, h);
    rng(r, 15, 17, "base 3 on audio");
  endtask : t_src
  task automatic t_branch();
    wr(OFS_BRANCH_EN, 32'h0000_A5A5, RESP_OKAY);
    repeat (40) @(posedge mclk);
    rdc(OFS_BRANCH_EN, 32'h0000_FFFF, 32'h0000_A5A5, "branch enables");
    seen = 32'h0000_0000;
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      seen |= 32'(branch_clk);
      n += int'(branch_clk[0] !== branch_clk[8]);
    end
    check(seen, 32'h0000_A5A5, "branch gating");
    check(32'(n), 32'h0000_0000, "branch phase");
  endtask : t_branch
  task automatic t_clock_output_pin();
    for (int s = 0; s < 4; s++) begin
      wr(OFS_CLOCK_OUTPUT_PIN_SEL, 32'(s), RESP_OKAY);
      repeat (40) @(posedge mclk);
      rdc(OFS_STATUS, 32'h0003_0000, 32'(s << 16), "output select");
      n = 0;
      repeat (40) begin
        @(posedge mclk);
        n += int'(clock_output_pin !== base_clk[s]) + int'(cpu_clock !== base_clk[0]);
      end
      check(32'(n), 32'h0000_0000, "output follows base");
    end
  endtask : t_clock_output_pin
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'b1000;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h0_0000;
    {s_axi_wdata, num_errors, n_compared} = '0;
    s_axi_wstrb = 4'hF;
    t_reset();
    t_pll();
    t_audio();
    t_src();
    t_branch();
    t_clock_output_pin();
    t_reset();
    close_out();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    close_out();
  end
endmodule : tb_top
